// [inc/iorms_pkg.sv]
// Package for the internal-oscillator run-mode clock switch.
// Assumes a single 100 MHz control clock and a plain strobe register port.
package iorms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and offsets.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the control register.
  localparam int CTRL_SEL_LO_POS = 0;
  localparam int CTRL_SEL_HI_POS = 1;
  localparam int CTRL_FREQ_POS = 2;
  localparam int CTRL_FREQ_W = 3;
  localparam int CTRL_IDLE_POS = 7;

  // Field positions of the status register.
  localparam int STAT_STABLE_POS = 0;
  localparam int STAT_RUNNING_POS = 1;
  localparam int STAT_MODE_POS = 2;

  // Reset values: primary clock runs, internal frequency field is zero.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] FREQ_OFF = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: clock rate, oscillator settling time and clock switch gap.
  localparam int CLK_FREQ_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STABLE_TIME_US = 1000;
  localparam int STABLE_CYCLES = STABLE_TIME_US * CLK_FREQ_MHZ;
  localparam int SWITCH_TIME_NS = 80;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout, most significant field first.
  typedef struct packed {
    logic idle_on_sleep_enable;
    logic [1:0] reserved;
    logic [2:0] internal_freq_select;
    logic clock_select_upper;
    logic clock_select_lower;
  } iorms_ctrl_t;

  // Status register layout, most significant field first.
  typedef struct packed {
    logic [2:0] reserved;
    logic [2:0] mode;
    logic primary_clock_running;
    logic internal_freq_stable;
  } iorms_status_t;

  // Clock switching states.
  typedef enum logic [2:0] {
    ST_PRIMARY_CLOCK_RUN_MODE = 3'b000,
    ST_SWITCH_TO_INTERNAL = 3'b001,
    ST_INTERNAL_CLOCK_RUN_MODE = 3'b010,
    ST_PRIMARY_STARTUP = 3'b011,
    ST_SWITCH_TO_PRIMARY = 3'b100
  } iorms_state_t;

endpackage

// [rtl/iorms_switch.sv]
// Clock source switching between the primary oscillator and the internal
// oscillator multiplexer, with frequency select and status flags.
// Assumes the CPU pulses sleep_exec_in for one cycle on the same clock, and
// that the wake and oscillator-ready inputs come from other domains.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module iorms_switch #(
  parameter int STABLE_CYCLES = iorms_pkg::STABLE_CYCLES,
  parameter int SWITCH_CYCLES = iorms_pkg::SWITCH_CYCLES
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [iorms_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [iorms_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [iorms_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic sleep_exec_in,
  input wire logic wakeup_in,
  input wire logic primary_ready_in,
  input wire logic watchdog_timer_enable_in,
  input wire logic clock_monitor_enable_in,
  output logic primary_osc_enable_out,
  output logic fast_osc_enable_out,
  output logic slow_rc_enable_out,
  output logic primary_gate_out,
  output logic internal_gate_out,
  output logic [2:0] internal_freq_select_out,
  output logic internal_clock_run_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants sized to the counters they meet.
  localparam logic [16:0] STABLE_LAST = 17'(STABLE_CYCLES - 1);
  localparam logic [7:0] SWITCH_LAST = 8'(SWITCH_CYCLES - 1);

  // True while both clock gates are held off between sources.
  function automatic logic in_switch_gap(input iorms_pkg::iorms_state_t st);
    in_switch_gap = (st == iorms_pkg::ST_SWITCH_TO_INTERNAL) ||
                    (st == iorms_pkg::ST_SWITCH_TO_PRIMARY);
  endfunction

  iorms_pkg::iorms_ctrl_t ctrl_r;
  iorms_pkg::iorms_state_t state_r;
  iorms_pkg::iorms_state_t state_nxt;
  logic [7:0] sw_cnt_r;
  logic [16:0] stable_cnt_r;
  logic stable_r;
  logic running_r;
  logic hold_off_r;
  logic prim_osc_en_r;
  logic primary_gate_r;
  logic internal_gate_r;
  logic slow_rc_en_r;
  logic wake_meta_r;
  logic wake_sync_r;
  logic ready_meta_r;
  logic ready_sync_r;
  logic ctrl_wr;
  logic switch_done;
  logic fast_en;
  logic enter_req;
  iorms_pkg::iorms_status_t status;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the wake and oscillator-ready pins.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wake_meta_r <= 1'b0;
      wake_sync_r <= 1'b0;
      ready_meta_r <= 1'b0;
      ready_sync_r <= 1'b0;
    end else if (clk_en_in) begin
      wake_meta_r <= wakeup_in;
      wake_sync_r <= wake_meta_r;
      ready_meta_r <= primary_ready_in;
      ready_sync_r <= ready_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register. Only software writes it; wake-up never touches it.
  assign ctrl_wr = reg_wr_in && (reg_addr_in == iorms_pkg::CTRL_OFS);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctrl_r <= iorms_pkg::CTRL_RST;
    end else if (clk_en_in && ctrl_wr) begin
      ctrl_r <= reg_wdata_in;
      ctrl_r.reserved <= 2'h0;
    end
  end

  // The frequency field goes straight to the oscillator mux, no sleep needed.
  assign internal_freq_select_out = ctrl_r.internal_freq_select;

  ////////////////////////////////////////////////////////////////////////////
  // Mode entry ignores the lower select bit.
  assign enter_req = sleep_exec_in && !ctrl_r.idle_on_sleep_enable &&
                     ctrl_r.clock_select_upper;
  assign switch_done = in_switch_gap(state_r) && (sw_cnt_r == SWITCH_LAST);

  // Next-state logic of the source switch sequence.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE: begin
        if (enter_req) begin
          state_nxt = iorms_pkg::ST_SWITCH_TO_INTERNAL;
        end
      end
      iorms_pkg::ST_SWITCH_TO_INTERNAL: begin
        if (switch_done) begin
          state_nxt = iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE;
        end
      end
      iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE: begin
        if (wake_sync_r) begin
          state_nxt = iorms_pkg::ST_PRIMARY_STARTUP;
        end
      end
      iorms_pkg::ST_PRIMARY_STARTUP: begin
        if (ready_sync_r) begin
          state_nxt = iorms_pkg::ST_SWITCH_TO_PRIMARY;
        end
      end
      iorms_pkg::ST_SWITCH_TO_PRIMARY: begin
        if (switch_done) begin
          state_nxt = iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE;
        end
      end
      default: begin
        state_nxt = iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_r <= iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  // Switch gap counter; the gap is taken even if both sources are the same.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sw_cnt_r <= 8'h00;
    end else if (clk_en_in) begin
      if (in_switch_gap(state_r) && !switch_done) begin
        sw_cnt_r <= sw_cnt_r + 8'h01;
      end else begin
        sw_cnt_r <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates. Both drop for the whole gap before the new one opens, so
  // no shortened pulse reaches the system clock net.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      primary_gate_r <= 1'b1;
      internal_gate_r <= 1'b0;
    end else if (clk_en_in) begin
      primary_gate_r <= (state_nxt == iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE);
      internal_gate_r <= (state_nxt == iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE) ||
                         (state_nxt == iorms_pkg::ST_PRIMARY_STARTUP);
    end
  end

  // Primary oscillator is stopped only while running from the internal mux.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prim_osc_en_r <= 1'b1;
    end else if (clk_en_in) begin
      prim_osc_en_r <= (state_nxt != iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE);
    end
  end

  // Primary-running flag, owned by this logic alone.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      running_r <= 1'b1;
    end else if (clk_en_in && switch_done) begin
      running_r <= (state_r == iorms_pkg::ST_SWITCH_TO_PRIMARY);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // After the return to primary the fast oscillator is parked until software
  // writes the control register again, so the stable flag stays clear.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      hold_off_r <= 1'b0;
    end else if (clk_en_in) begin
      if (switch_done && (state_r == iorms_pkg::ST_SWITCH_TO_PRIMARY)) begin
        hold_off_r <= 1'b1;
      end else if (ctrl_wr) begin
        hold_off_r <= 1'b0;
      end
    end
  end

  assign fast_en = (ctrl_r.internal_freq_select != iorms_pkg::FREQ_OFF) && !hold_off_r;
  assign fast_osc_enable_out = fast_en;

  // Settling counter; the system keeps its clock while it runs. Completing the
  // return to primary clears the flag at the same edge as the running flag.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      stable_cnt_r <= 17'h00000;
      stable_r <= 1'b0;
    end else if (clk_en_in) begin
      if (!fast_en || (switch_done && (state_r == iorms_pkg::ST_SWITCH_TO_PRIMARY))) begin
        stable_cnt_r <= 17'h00000;
        stable_r <= 1'b0;
      end else if (stable_cnt_r != STABLE_LAST) begin
        stable_cnt_r <= stable_cnt_r + 17'h00001;
      end else begin
        stable_r <= 1'b1;
      end
    end
  end

  // Slow RC source: needed by the watchdog, the clock monitor, or as the
  // internal clock when the fast oscillator is off (frequency field zero or parked).
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      slow_rc_en_r <= 1'b0;
    end else if (clk_en_in) begin
      slow_rc_en_r <= watchdog_timer_enable_in || clock_monitor_enable_in ||
                      (!fast_en && (state_nxt != iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port. Status writes fall on nothing, so the flags stay read-only.
  always_comb begin
    status = '0;
    status.mode = state_r;
    status.primary_clock_running = running_r;
    status.internal_freq_stable = stable_r;
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      if (reg_rd_in && (reg_addr_in == iorms_pkg::CTRL_OFS)) begin
        reg_rdata_out <= ctrl_r;
      end else if (reg_rd_in && (reg_addr_in == iorms_pkg::STATUS_OFS)) begin
        reg_rdata_out <= status;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  assign primary_osc_enable_out = prim_osc_en_r;
  assign primary_gate_out = primary_gate_r;
  assign internal_gate_out = internal_gate_r;
  assign slow_rc_enable_out = slow_rc_en_r;
  assign internal_clock_run_mode_out = (state_r == iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the switching behaviour.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence wake_seen_s;
    clk_en_in && (state_r == iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE) && wake_sync_r;
  endsequence

  sequence primary_restart_s;
    (state_r == iorms_pkg::ST_PRIMARY_STARTUP) && internal_gate_r && prim_osc_en_r;
  endsequence

  gates_never_both_a: assert property (!(primary_gate_r && internal_gate_r))
    else $error("Both clock gates open at once.");

  internal_mode_clock_a: assert property (
    (state_r == iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE) |-> internal_gate_r && !prim_osc_en_r)
    else $error("Internal mode without internal clock or with primary running.");

  mode_entry_a: assert property (
    clk_en_in && (state_r == iorms_pkg::ST_PRIMARY_CLOCK_RUN_MODE) && sleep_exec_in &&
    !ctrl_r.idle_on_sleep_enable && ctrl_r.clock_select_upper
    |=> state_r == iorms_pkg::ST_SWITCH_TO_INTERNAL)
    else $error("Sleep with entry conditions did not start the switch.");

  entry_stops_primary_a: assert property (
    $rose(state_r == iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE) |-> !running_r && !prim_osc_en_r)
    else $error("Primary still marked running after switchover.");

  freq_immediate_a: assert property (clk_en_in && ctrl_wr
    |=> internal_freq_select_out == $past(reg_wdata_in[4:2]))
    else $error("Frequency field did not follow the write.");

  zero_freq_a: assert property (
    (ctrl_r.internal_freq_select == iorms_pkg::FREQ_OFF)[*2] |-> !stable_r && !fast_en)
    else $error("Stable flag or fast oscillator on with zero frequency.");

  stable_after_count_a: assert property ($rose(stable_r) |-> stable_cnt_r == STABLE_LAST)
    else $error("Stable flag set before the settling count.");

  entry_keeps_stable_a: assert property (
    clk_en_in && (state_r == iorms_pkg::ST_SWITCH_TO_INTERNAL) && stable_r && !ctrl_wr
    |=> stable_r)
    else $error("Stable flag lost during mode entry.");

  wake_restart_a: assert property (wake_seen_s |=> primary_restart_s)
    else $error("Wake did not start the primary while on internal clock.");

  return_gap_a: assert property (
    clk_en_in && (state_r == iorms_pkg::ST_PRIMARY_STARTUP) && ready_sync_r
    |=> !internal_gate_r && !primary_gate_r)
    else $error("Primary ready did not begin the switch back.");

  return_done_a: assert property (
    $fell(state_r == iorms_pkg::ST_SWITCH_TO_PRIMARY) |-> running_r && !stable_r && primary_gate_r)
    else $error("Return to primary left wrong flags.");

  ctrl_untouched_a: assert property (!(clk_en_in && ctrl_wr) |=> $stable(ctrl_r))
    else $error("Control bits changed without a write.");

  slow_rc_kept_a: assert property (
    clk_en_in && (watchdog_timer_enable_in || clock_monitor_enable_in) |=> slow_rc_en_r)
    else $error("Slow RC stopped while watchdog or monitor enabled.");

  entry_gap_a: assert property (
    $rose(state_r == iorms_pkg::ST_SWITCH_TO_INTERNAL) |-> (!internal_gate_r && !primary_gate_r)[*2])
    else $error("Entry switch gap shorter than two cycles.");

endmodule // iorms_switch

`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the internal-oscillator run-mode clock switch.
// Assumes the design and its package are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int STB = 20;
  localparam int SWG = 8;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic sleep_exec_in = 1'b0;
  logic wakeup_in = 1'b0;
  logic primary_ready_in = 1'b0;
  logic watchdog_timer_enable_in = 1'b0;
  logic clock_monitor_enable_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic primary_osc_enable_out;
  logic fast_osc_enable_out;
  logic slow_rc_enable_out;
  logic primary_gate_out;
  logic internal_gate_out;
  logic [2:0] internal_freq_select_out;
  logic internal_clock_run_mode_out;
  logic [7:0] rv;
  int n;
  int err_count = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock; the clock enable stays high since freezing is not a rule.
  always #5 clock_in = ~clock_in;

  iorms_switch #(.STABLE_CYCLES(STB), .SWITCH_CYCLES(SWG)) dut_u (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sleep_exec_in(sleep_exec_in),
    .wakeup_in(wakeup_in), .primary_ready_in(primary_ready_in),
    .watchdog_timer_enable_in(watchdog_timer_enable_in),
    .clock_monitor_enable_in(clock_monitor_enable_in),
    .primary_osc_enable_out(primary_osc_enable_out), .fast_osc_enable_out(fast_osc_enable_out),
    .slow_rc_enable_out(slow_rc_enable_out), .primary_gate_out(primary_gate_out),
    .internal_gate_out(internal_gate_out), .internal_freq_select_out(internal_freq_select_out),
    .internal_clock_run_mode_out(internal_clock_run_mode_out));

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison, verdict and bus tasks.
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Control byte from its fields: idle bit, frequency, upper and lower select.
  function logic [7:0] cb(input logic idle, input logic [2:0] f, input logic hi, input logic lo);
    cb = {idle, 2'h0, f, hi, lo};
  endfunction

  function logic [7:0] st(input logic [2:0] m, input logic run, input logic stb);
    st = {3'h0, m, run, stb};
  endfunction

  function logic sig(input int i);
    case (i)
      0: sig = primary_gate_out;
      1: sig = internal_gate_out;
      default: sig = primary_osc_enable_out;
    endcase
  endfunction

  // Counts edges until the chosen output reaches the level; a long wait ends the run.
  task wait_sig(input int i, input logic v, output int c);
    c = 0;
    while (sig(i) !== v) begin
      @(posedge clock_in);
      #1;
      c++;
      if (c > 200 && sig(i) !== v) begin
        chk(sig(i), v);
        give_verdict();
      end
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the taking edge, so sample there.
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  task pulse_sleep;
    @(posedge clock_in);
    sleep_exec_in <= 1'b1;
    @(posedge clock_in);
    sleep_exec_in <= 1'b0;
    #1;
  endtask

  // Polls status until the stable flag shows, with a bounded number of reads.
  task wait_stable;
    rv = 8'h00;
    for (int k = 0; k < 12 && rv[0] !== 1'b1; k++) rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv[0], 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_reset;
    rd(iorms_pkg::CTRL_OFS, rv);
    chk(rv, iorms_pkg::CTRL_RST);
    rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv, st(3'h0, 1'b1, 1'b0));
    rd(8'h7F, rv);
    chk(rv, 8'h00);
    wr(iorms_pkg::STATUS_OFS, 8'hFF);
    rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv, st(3'h0, 1'b1, 1'b0));
    chk(primary_gate_out, 1'b1);
    chk(fast_osc_enable_out, 1'b0);
  endtask

  // Frequency change acts at once; the stable flag waits for the settling count.
  task t_freq;
    wr(iorms_pkg::CTRL_OFS, cb(1'b0, 3'h5, 1'b0, 1'b0));
    chk(internal_freq_select_out, 3'h5);
    chk(fast_osc_enable_out, 1'b1);
    repeat (STB - 6) @(posedge clock_in);
    rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv[0], 1'b0);
    wait_stable();
    wr(iorms_pkg::CTRL_OFS, cb(1'b0, 3'h0, 1'b0, 1'b0));
    chk(fast_osc_enable_out, 1'b0);
    rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv[0], 1'b0);
  endtask

  // Sleep with idle set, or with the upper select clear, must not switch.
  task t_refuse;
    wr(iorms_pkg::CTRL_OFS, cb(1'b1, 3'h5, 1'b1, 1'b0));
    pulse_sleep();
    repeat (SWG + 4) @(posedge clock_in);
    #1;
    chk(primary_gate_out, 1'b1);
    wr(iorms_pkg::CTRL_OFS, cb(1'b0, 3'h5, 1'b0, 1'b1));
    pulse_sleep();
    repeat (SWG + 4) @(posedge clock_in);
    #1;
    chk(primary_gate_out, 1'b1);
    chk(internal_clock_run_mode_out, 1'b0);
    wait_stable();
  endtask

  // Entry with the lower select set too, which must be ignored.
  task t_entry;
    wr(iorms_pkg::CTRL_OFS, cb(1'b0, 3'h5, 1'b1, 1'b1));
    pulse_sleep();
    wait_sig(0, 1'b0, n);
    chk(internal_gate_out, 1'b0);
    wait_sig(1, 1'b1, n);
    chk(8'(n), 8'(SWG));
    chk(primary_osc_enable_out, 1'b0);
    chk(primary_gate_out, 1'b0);
    chk(internal_clock_run_mode_out, 1'b1);
    rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv, st(iorms_pkg::ST_INTERNAL_CLOCK_RUN_MODE, 1'b0, 1'b1));
    wr(iorms_pkg::CTRL_OFS, cb(1'b0, 3'h3, 1'b1, 1'b1));
    chk(internal_freq_select_out, 3'h3);
  endtask

  // Either enable keeps the slow RC source running in internal mode.
  task t_slow_rc;
    @(posedge clock_in);
    watchdog_timer_enable_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk(slow_rc_enable_out, 1'b1);
    @(posedge clock_in);
    watchdog_timer_enable_in <= 1'b0;
    clock_monitor_enable_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk(slow_rc_enable_out, 1'b1);
    @(posedge clock_in);
    clock_monitor_enable_in <= 1'b0;
  endtask

  // Wake restarts the primary under the internal clock, then switches back.
  task t_wake;
    @(posedge clock_in);
    wakeup_in <= 1'b1;
    wait_sig(2, 1'b1, n);
    chk(internal_gate_out, 1'b1);
    chk(primary_gate_out, 1'b0);
    @(posedge clock_in);
    wakeup_in <= 1'b0;
    primary_ready_in <= 1'b1;
    wait_sig(1, 1'b0, n);
    chk(primary_gate_out, 1'b0);
    wait_sig(0, 1'b1, n);
    chk(8'(n), 8'(SWG));
    chk(internal_clock_run_mode_out, 1'b0);
    rd(iorms_pkg::STATUS_OFS, rv);
    chk(rv, st(3'h0, 1'b1, 1'b0));
    rd(iorms_pkg::CTRL_OFS, rv);
    chk(rv, cb(1'b0, 3'h3, 1'b1, 1'b1));
    @(posedge clock_in);
    primary_ready_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: six reset cycles, then each scenario in turn.
  initial begin
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_freq();
    t_refuse();
    t_entry();
    t_slow_rc();
    t_wake();
    give_verdict();
  end
endmodule // tb

`default_nettype wire
